// ---- include/sgs_pkg.sv ----
// constants and types for the stop-grant sequencer
package sgs_pkg;
  // bus cycle kinds requested of the cycle driver
  typedef enum logic [2:0] {
    SGS_KIND_MEM  = 3'h0,
    SGS_KIND_CODE = 3'h1,
    SGS_KIND_IO   = 3'h2,
    SGS_KIND_INTA = 3'h3,
    SGS_KIND_SPEC = 3'h4
  } sgs_kind_t;

  // stop sequencer states
  typedef enum logic [5:0] {
    SGS_RUN   = 6'h01,
    SGS_FLUSH = 6'h02,
    SGS_DRAIN = 6'h04,
    SGS_SGCYC = 6'h08,
    SGS_WBUF  = 6'h10,
    SGS_GRANT = 6'h20
  } sgs_state_t;

  // cycle driver states
  typedef enum logic [3:0] {
    SGS_C_IDLE = 4'h1,
    SGS_C_BUSY = 4'h2,
    SGS_C_BACKOFF_N = 4'h4,
    SGS_C_HOLD = 4'h8
  } sgs_cstate_t;

  // bus cycle definition bits: memory/io, data/code, write/read, cache indication
  localparam logic SGS_SPEC_MIO   = 1'h0;
  localparam logic SGS_SPEC_DC    = 1'h0;
  localparam logic SGS_SPEC_WR    = 1'h1;
  localparam logic SGS_SPEC_CACHE = 1'h1;
  localparam logic SGS_INTA_WR    = 1'h0;
  localparam logic SGS_CODE_WR    = 1'h0;

  // stop-grant special cycle is a single transfer
  localparam logic [1:0] SGS_SPEC_BEATS = 2'h0;
  localparam int         SGS_FLUSH_CYC  = 3;
endpackage : sgs_pkg

// ---- core/sgs_bus_cycle.sv ----
// bus cycle driver: strobe, cycle definition outputs and write/read float control
`timescale 1ns/10ps
module sgs_bus_cycle (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire sgs_pkg::sgs_kind_t kind,
  input  wire logic             is_write,
  input  wire logic [1:0]       last_beat,
  input  wire logic             burst_ready_n,
  input  wire logic             next_address_n,
  input  wire logic             backoff_n,
  input  wire logic             hold_request,
  output logic                  accept,
  output logic                  idle,
  output logic                  done,
  output logic                  address_strobe_n,
  output logic                  write_read,
  output logic                  write_read_oe,
  output logic                  mem_io,
  output logic                  data_code,
  output logic                  cache_ind,
  output logic                  hold_acknowledge
);
  sgs_pkg::sgs_cstate_t st_r, st_nxt;
  sgs_pkg::sgs_kind_t   kind_r, kind_nxt;
  logic       wr_r, wr_nxt, oe_r, oe_nxt, ads_n_r, ads_n_nxt;
  logic       mio_r, mio_nxt, dc_r, dc_nxt, cache_r, cache_nxt;
  logic       hold_acknowledge_r, hold_acknowledge_nxt, done_r, done_nxt, na_r, na_nxt, isw_r, isw_nxt;
  logic [1:0] beat_r, beat_nxt, last_r, last_nxt;
  logic       last_hit;

  assign last_hit = !burst_ready_n && (beat_r == last_r);

  always_comb begin
    st_nxt    = st_r;
    kind_nxt  = kind_r;
    isw_nxt   = isw_r;
    wr_nxt    = wr_r;
    oe_nxt    = oe_r;
    ads_n_nxt = 1'h1;
    mio_nxt   = mio_r;
    dc_nxt    = dc_r;
    cache_nxt = cache_r;
    hold_acknowledge_nxt  = hold_acknowledge_r;
    done_nxt  = 1'h0;
    na_nxt    = na_r;
    beat_nxt  = beat_r;
    last_nxt  = last_r;
    accept    = 1'h0;
    case (st_r)
      sgs_pkg::SGS_C_IDLE: begin
        if (hold_request) begin
          st_nxt   = sgs_pkg::SGS_C_HOLD;
          hold_acknowledge_nxt = 1'h1;
          oe_nxt   = 1'h0;
        end else if (!backoff_n) begin
          oe_nxt = 1'h0;
        end else if (start) begin
          accept = 1'h1;
        end
      end
      sgs_pkg::SGS_C_BUSY: begin
        if (!backoff_n) begin
          st_nxt    = sgs_pkg::SGS_C_BACKOFF_N;
          oe_nxt    = 1'h0;
        end else begin
          if (!next_address_n) begin
            na_nxt = 1'h1;
          end
          if (last_hit) begin
            done_nxt = 1'h1;
            st_nxt   = sgs_pkg::SGS_C_IDLE;
            // pipelined start only once next-address was granted
            if (start && (na_r || !next_address_n) && !hold_request) begin
              accept = 1'h1;
            end
          end else if (!burst_ready_n) begin
            beat_nxt = beat_r + 2'h1;
          end
        end
      end
      sgs_pkg::SGS_C_BACKOFF_N: begin
        // aborted cycle restarts from the first transfer
        if (backoff_n) begin
          st_nxt    = sgs_pkg::SGS_C_BUSY;
          ads_n_nxt = 1'h0;
          oe_nxt    = 1'h1;
          beat_nxt  = 2'h0;
          na_nxt    = 1'h0;
        end
      end
      sgs_pkg::SGS_C_HOLD: begin
        if (!hold_request) begin
          st_nxt   = sgs_pkg::SGS_C_IDLE;
          hold_acknowledge_nxt = 1'h0;
        end
      end
      default: begin
        st_nxt = sgs_pkg::SGS_C_IDLE;
      end
    endcase
    if (accept) begin
      st_nxt    = sgs_pkg::SGS_C_BUSY;
      ads_n_nxt = 1'h0;
      oe_nxt    = 1'h1;
      kind_nxt  = kind;
      isw_nxt   = is_write;
      last_nxt  = last_beat;
      beat_nxt  = 2'h0;
      na_nxt    = 1'h0;
      case (kind)
        sgs_pkg::SGS_KIND_SPEC: begin
          mio_nxt   = sgs_pkg::SGS_SPEC_MIO;
          dc_nxt    = sgs_pkg::SGS_SPEC_DC;
          wr_nxt    = sgs_pkg::SGS_SPEC_WR;
          cache_nxt = sgs_pkg::SGS_SPEC_CACHE;
        end
        sgs_pkg::SGS_KIND_INTA: begin
          mio_nxt   = 1'h0;
          dc_nxt    = 1'h0;
          wr_nxt    = sgs_pkg::SGS_INTA_WR;
          cache_nxt = 1'h1;
        end
        sgs_pkg::SGS_KIND_IO: begin
          mio_nxt   = 1'h0;
          dc_nxt    = 1'h1;
          wr_nxt    = is_write;
          cache_nxt = 1'h1;
        end
        sgs_pkg::SGS_KIND_CODE: begin
          mio_nxt   = 1'h1;
          dc_nxt    = 1'h0;
          wr_nxt    = sgs_pkg::SGS_CODE_WR;
          cache_nxt = 1'h1;
        end
        default: begin
          mio_nxt   = 1'h1;
          dc_nxt    = 1'h1;
          wr_nxt    = is_write;
          cache_nxt = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r    <= sgs_pkg::SGS_C_IDLE;
      kind_r  <= sgs_pkg::SGS_KIND_MEM;
      isw_r   <= 1'h0;
      wr_r    <= 1'h0;
      oe_r    <= 1'h0;
      ads_n_r <= 1'h1;
      mio_r   <= 1'h0;
      dc_r    <= 1'h0;
      cache_r <= 1'h1;
      hold_acknowledge_r  <= 1'h0;
      done_r  <= 1'h0;
      na_r    <= 1'h0;
      beat_r  <= 2'h0;
      last_r  <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      kind_r  <= kind_nxt;
      isw_r   <= isw_nxt;
      wr_r    <= wr_nxt;
      oe_r    <= oe_nxt;
      ads_n_r <= ads_n_nxt;
      mio_r   <= mio_nxt;
      dc_r    <= dc_nxt;
      cache_r <= cache_nxt;
      hold_acknowledge_r  <= hold_acknowledge_nxt;
      done_r  <= done_nxt;
      na_r    <= na_nxt;
      beat_r  <= beat_nxt;
      last_r  <= last_nxt;
    end
  end

  assign idle             = (st_r == sgs_pkg::SGS_C_IDLE);
  assign done             = done_r;
  assign address_strobe_n = ads_n_r;
  assign write_read       = wr_r;
  assign write_read_oe    = oe_r;
  assign mem_io           = mio_r;
  assign data_code        = dc_r;
  assign cache_ind        = cache_r;
  assign hold_acknowledge = hold_acknowledge_r;
endmodule : sgs_bus_cycle

// ---- core/sgs_sequencer.sv ----
// stop-grant sequencer top: stop request handling, core clock gate, bus cycle issue
`timescale 1ns/10ps
module sgs_sequencer #(
  parameter int FLUSH_CYC = sgs_pkg::SGS_FLUSH_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic               stop_request_n,
  input  wire logic               write_buffer_empty_n,
  input  wire logic               write_buffer_mask,
  input  wire logic               bus_clock_stopped,
  input  wire logic               core_boundary,
  input  wire logic               core_bus_pending,
  input  wire logic               core_cyc_req,
  input  wire sgs_pkg::sgs_kind_t core_cyc_kind,
  input  wire logic               core_cyc_write,
  input  wire logic [1:0]         core_cyc_last_beat,
  input  wire logic               burst_ready_n,
  input  wire logic               next_address_n,
  input  wire logic               backoff_n,
  input  wire logic               hold_request,
  output logic                    core_cyc_busy,
  output logic                    core_cyc_done,
  output logic                    core_clk_run,
  output logic                    core_flush,
  output logic                    stop_grant_state,
  output logic                    stop_clock_state,
  output logic                    address_strobe_n,
  output logic                    write_read,
  output logic                    write_read_oe,
  output logic                    mem_io,
  output logic                    data_code,
  output logic                    cache_ind,
  output logic                    hold_acknowledge
);
  localparam int FCW = $clog2(FLUSH_CYC + 1);

  sgs_pkg::sgs_state_t st_r, st_nxt;
  logic           stop_req_r, stop_req_nxt;
  logic [FCW-1:0] fcnt_r, fcnt_nxt;
  logic           pend_r, pend_nxt;
  sgs_pkg::sgs_kind_t pkind_r, pkind_nxt;
  logic           pwr_r, pwr_nxt;
  logic [1:0]     plast_r, plast_nxt;
  logic           sg_issued_r, sg_issued_nxt;
  logic           sg_burst_ready_n_r, sg_burst_ready_n_nxt;
  logic           run_r, run_nxt, flush_r, flush_nxt;
  logic           grant_r, grant_nxt, sclk_r, sclk_nxt, cdone_r, cdone_nxt;
  logic           wb_ok;
  logic           sg_start, cyc_start;
  sgs_pkg::sgs_kind_t cyc_kind;
  logic           cyc_write;
  logic [1:0]     cyc_last;
  logic           drv_accept, drv_idle, drv_done;

  assign wb_ok = write_buffer_mask || !write_buffer_empty_n;

  // stop-grant cycle has priority once the bus is drained
  assign sg_start  = (st_r == sgs_pkg::SGS_SGCYC) && !sg_issued_r;
  assign cyc_start = sg_start || pend_r;
  assign cyc_kind  = sg_start ? sgs_pkg::SGS_KIND_SPEC : pkind_r;
  assign cyc_write = sg_start ? sgs_pkg::SGS_SPEC_WR : pwr_r;
  assign cyc_last  = sg_start ? sgs_pkg::SGS_SPEC_BEATS : plast_r;

  always_comb begin
    st_nxt        = st_r;
    stop_req_nxt  = !stop_request_n;
    fcnt_nxt      = fcnt_r;
    sg_issued_nxt = sg_issued_r;
    sg_burst_ready_n_nxt   = sg_burst_ready_n_r;
    pend_nxt      = pend_r;
    pkind_nxt     = pkind_r;
    pwr_nxt       = pwr_r;
    plast_nxt     = plast_r;
    cdone_nxt     = drv_done && !sg_issued_r;
    // one request at a time; taken while core still runs
    if (pend_r && drv_accept && !sg_start) begin
      pend_nxt = 1'h0;
    end else if (!pend_r && core_cyc_req && run_r) begin
      pend_nxt  = 1'h1;
      pkind_nxt = core_cyc_kind;
      pwr_nxt   = core_cyc_write;
      plast_nxt = core_cyc_last_beat;
    end
    case (st_r)
      sgs_pkg::SGS_RUN: begin
        if (stop_req_r && core_boundary) begin
          st_nxt   = sgs_pkg::SGS_FLUSH;
          fcnt_nxt = FCW'(FLUSH_CYC);
        end
      end
      sgs_pkg::SGS_FLUSH: begin
        if (fcnt_r == '0) begin
          st_nxt = sgs_pkg::SGS_DRAIN;
        end else begin
          fcnt_nxt = fcnt_r - FCW'(1);
        end
      end
      sgs_pkg::SGS_DRAIN: begin
        if (!core_bus_pending && !pend_r && drv_idle) begin
          st_nxt        = sgs_pkg::SGS_SGCYC;
          sg_issued_nxt = 1'h0;
          sg_burst_ready_n_nxt   = 1'h0;
        end
      end
      sgs_pkg::SGS_SGCYC: begin
        if (sg_start && drv_accept) begin
          sg_issued_nxt = 1'h1;
        end
        if (sg_issued_r && drv_done) begin
          sg_burst_ready_n_nxt = 1'h1;
          st_nxt      = wb_ok ? sgs_pkg::SGS_GRANT : sgs_pkg::SGS_WBUF;
        end
      end
      sgs_pkg::SGS_WBUF: begin
        if (wb_ok) begin
          st_nxt = sgs_pkg::SGS_GRANT;
        end
      end
      sgs_pkg::SGS_GRANT: begin
        if (!bus_clock_stopped && !stop_req_r) begin
          st_nxt        = sgs_pkg::SGS_RUN;
          sg_issued_nxt = 1'h0;
          sg_burst_ready_n_nxt   = 1'h0;
        end
      end
      default: begin
        st_nxt = sgs_pkg::SGS_RUN;
      end
    endcase
    run_nxt   = (st_nxt == sgs_pkg::SGS_RUN);
    flush_nxt = (st_nxt == sgs_pkg::SGS_FLUSH);
    grant_nxt = (st_nxt == sgs_pkg::SGS_GRANT);
    sclk_nxt  = grant_nxt && bus_clock_stopped;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r        <= sgs_pkg::SGS_RUN;
      stop_req_r  <= 1'h0;
      fcnt_r      <= '0;
      pend_r      <= 1'h0;
      pkind_r     <= sgs_pkg::SGS_KIND_MEM;
      pwr_r       <= 1'h0;
      plast_r     <= 2'h0;
      sg_issued_r <= 1'h0;
      sg_burst_ready_n_r   <= 1'h0;
      run_r       <= 1'h1;
      flush_r     <= 1'h0;
      grant_r     <= 1'h0;
      sclk_r      <= 1'h0;
      cdone_r     <= 1'h0;
    end else begin
      st_r        <= st_nxt;
      stop_req_r  <= stop_req_nxt;
      fcnt_r      <= fcnt_nxt;
      pend_r      <= pend_nxt;
      pkind_r     <= pkind_nxt;
      pwr_r       <= pwr_nxt;
      plast_r     <= plast_nxt;
      sg_issued_r <= sg_issued_nxt;
      sg_burst_ready_n_r   <= sg_burst_ready_n_nxt;
      run_r       <= run_nxt;
      flush_r     <= flush_nxt;
      grant_r     <= grant_nxt;
      sclk_r      <= sclk_nxt;
      cdone_r     <= cdone_nxt;
    end
  end

  sgs_bus_cycle u_cycle (
    .sys_clk          (sys_clk),
    .srst             (srst),
    .start            (cyc_start),
    .kind             (cyc_kind),
    .is_write         (cyc_write),
    .last_beat        (cyc_last),
    .burst_ready_n    (burst_ready_n),
    .next_address_n   (next_address_n),
    .backoff_n        (backoff_n),
    .hold_request     (hold_request),
    .accept           (drv_accept),
    .idle             (drv_idle),
    .done             (drv_done),
    .address_strobe_n (address_strobe_n),
    .write_read       (write_read),
    .write_read_oe    (write_read_oe),
    .mem_io           (mem_io),
    .data_code        (data_code),
    .cache_ind        (cache_ind),
    .hold_acknowledge (hold_acknowledge)
  );

  assign core_cyc_busy    = pend_r;
  assign core_cyc_done    = cdone_r;
  assign core_clk_run     = run_r;
  assign core_flush       = flush_r;
  assign stop_grant_state = grant_r;
  assign stop_clock_state = sclk_r;
endmodule : sgs_sequencer

// ---- dv/sgs_seq_monitor.sv ----
// port checker for the stop-grant sequencer
`timescale 1ns/10ps
module sgs_seq_chk #(
  parameter int FLUSH_CYC = 3
) (
  input wire logic               sys_clk,
  input wire logic               srst,
  input wire logic               stop_request_n,
  input wire logic               write_buffer_empty_n,
  input wire logic               write_buffer_mask,
  input wire logic               bus_clock_stopped,
  input wire logic               core_boundary,
  input wire sgs_pkg::sgs_kind_t core_cyc_kind,
  input wire logic               core_cyc_write,
  input wire logic               core_cyc_busy,
  input wire logic               core_clk_run,
  input wire logic               core_flush,
  input wire logic               stop_grant_state,
  input wire logic               stop_clock_state,
  input wire logic               address_strobe_n,
  input wire logic               write_read,
  input wire logic               write_read_oe,
  input wire logic               mem_io,
  input wire logic               data_code,
  input wire logic               cache_ind,
  input wire logic               burst_ready_n,
  input wire logic               backoff_n,
  input wire logic               hold_acknowledge
);
  logic [7:0] fl_cnt_r;
  logic [7:0] fl_cnt_nxt;
  logic       exp_wr;
  // run length of the flush window
  always_comb begin
    fl_cnt_nxt = core_flush ? fl_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge sys_clk) begin
    fl_cnt_r <= srst ? 8'h00 : fl_cnt_nxt;
  end
  assign exp_wr = core_cyc_kind == sgs_pkg::SGS_KIND_SPEC ||
                  (core_cyc_write && core_cyc_kind inside {sgs_pkg::SGS_KIND_MEM, sgs_pkg::SGS_KIND_IO});
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_spec_code;
    !address_strobe_n && !core_clk_run |-> !mem_io && !data_code && write_read && cache_ind && write_read_oe;
  endproperty
  a_spec_code: assert property (p_spec_code) else $error("special cycle encoding wrong");
  property p_wr_kind;
    !address_strobe_n && $past(core_cyc_busy) |-> write_read_oe && write_read == $past(exp_wr);
  endproperty
  a_wr_kind: assert property (p_wr_kind) else $error("direction wrong at strobe");
  property p_wr_hold;
    write_read_oe && $past(write_read_oe) && address_strobe_n && $past(burst_ready_n) |-> $stable(write_read);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("direction moved mid cycle");
  property p_backoff_n;
    !backoff_n |=> !write_read_oe;
  endproperty
  a_backoff_n: assert property (p_backoff_n) else $error("direction driven after backoff");
  property p_hold_acknowledge;
    $rose(hold_acknowledge) |-> !write_read_oe;
  endproperty
  a_hold_acknowledge: assert property (p_hold_acknowledge) else $error("direction driven with hold ack");
  property p_grant_buf;
    $rose(stop_grant_state) |-> $past(write_buffer_mask) || !$past(write_buffer_empty_n);
  endproperty
  a_grant_buf: assert property (p_grant_buf) else $error("grant before buffers empty");
  property p_grant_core;
    stop_grant_state |-> !core_clk_run && !core_flush && address_strobe_n;
  endproperty
  a_grant_core: assert property (p_grant_core) else $error("core clock runs in grant");
  property p_flush_len;
    $fell(core_flush) |-> fl_cnt_r == 8'(FLUSH_CYC + 1);
  endproperty
  a_flush_len: assert property (p_flush_len) else $error("flush length wrong");
  property p_recog;
    $rose(core_flush) |-> $past(core_boundary) && !$past(stop_request_n, 2);
  endproperty
  a_recog: assert property (p_recog) else $error("flush without boundary");
  property p_sclk;
    stop_clock_state |-> stop_grant_state && $past(bus_clock_stopped);
  endproperty
  a_sclk: assert property (p_sclk) else $error("stop clock state wrong");
  property p_resume;
    $rose(core_clk_run) |-> $past(stop_request_n, 2) && !$past(bus_clock_stopped);
  endproperty
  a_resume: assert property (p_resume) else $error("early resume");
  c_grant: cover property ($rose(stop_grant_state));
  c_sclk: cover property (stop_clock_state);
  c_backoff_n: cover property (!backoff_n && write_read_oe);
endmodule : sgs_seq_chk

bind sgs_sequencer sgs_seq_chk #(.FLUSH_CYC(FLUSH_CYC)) i_sgs_seq_chk (
  .sys_clk, .srst, .stop_request_n, .write_buffer_empty_n, .write_buffer_mask, .bus_clock_stopped,
  .core_boundary, .core_cyc_kind, .core_cyc_write, .core_cyc_busy, .core_clk_run, .core_flush,
  .stop_grant_state, .stop_clock_state, .address_strobe_n, .write_read, .write_read_oe, .mem_io,
  .data_code, .cache_ind, .burst_ready_n, .backoff_n, .hold_acknowledge);

// ---- dv/sgs_sys_model.sv ----
// system-side model: answers bus cycles with burst ready
`timescale 1ns/10ps
module sgs_sys_model (
  input  wire logic       sys_clk,
  input  wire logic       address_strobe_n,
  input  wire logic       backoff_n,
  input  wire logic [1:0] beats_m1,
  input  wire logic [1:0] wait_cyc,
  output logic            burst_ready_n
);
  int cnt = 0;
  int left = 0;
  initial burst_ready_n = 1'h1;
  // settle past the bench's falling-edge writes first
  always @(negedge sys_clk) begin
    #1;
    if (!address_strobe_n) begin
      cnt = wait_cyc;
      left = beats_m1 + 1;
    end
    // backoff aborts the cycle, beats restart on reissue
    if (!backoff_n) left = 0;
    if (left > 0 && cnt == 0) begin
      burst_ready_n = 1'h0;
      left = left - 1;
    end else begin
      burst_ready_n = 1'h1;
      if (cnt > 0) cnt = cnt - 1;
    end
  end
endmodule : sgs_sys_model

// ---- dv/tb.sv ----
// self-checking bench for the stop-grant sequencer
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic stop_request_n = 1'h1;
  logic write_buffer_empty_n = 1'h0;
  logic write_buffer_mask = 1'h0;
  logic bus_clock_stopped = 1'h0;
  logic core_boundary = 1'h0;
  logic core_bus_pending = 1'h0;
  logic next_address_n = 1'h1;
  logic core_cyc_req = 1'h0;
  sgs_pkg::sgs_kind_t core_cyc_kind = sgs_pkg::SGS_KIND_MEM;
  logic core_cyc_write = 1'h0;
  logic [1:0] core_cyc_last_beat = 2'h0;
  logic [1:0] wait_cyc = 2'h0;
  logic backoff_n = 1'h1;
  logic hold_request = 1'h0;
  logic burst_ready_n, core_cyc_busy, core_cyc_done, core_clk_run, core_flush, stop_grant_state;
  logic stop_clock_state, address_strobe_n, write_read, write_read_oe, mem_io, data_code;
  logic cache_ind, hold_acknowledge;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 sys_clk = ~sys_clk;
  sgs_sequencer #(.FLUSH_CYC(3)) i_sgs_sequencer (
    .sys_clk, .srst, .stop_request_n, .write_buffer_empty_n, .write_buffer_mask, .bus_clock_stopped,
    .core_boundary, .core_bus_pending, .core_cyc_req, .core_cyc_kind, .core_cyc_write,
    .core_cyc_last_beat, .burst_ready_n, .next_address_n, .backoff_n, .hold_request,
    .core_cyc_busy, .core_cyc_done, .core_clk_run, .core_flush, .stop_grant_state, .stop_clock_state,
    .address_strobe_n, .write_read, .write_read_oe, .mem_io, .data_code, .cache_ind, .hold_acknowledge);
  sgs_sys_model i_sgs_sys_model (
    .sys_clk, .address_strobe_n, .backoff_n, .beats_m1(core_cyc_last_beat), .wait_cyc, .burst_ready_n);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic wait_ads();
    for (int i = 0; i < 40 && address_strobe_n !== 1'h0; i++) cyc(1);
    chk("strobe", 1'h0, address_strobe_n);
  endtask : wait_ads
  task automatic wait_done();
    for (int i = 0; i < 40 && core_cyc_done !== 1'h1; i++) cyc(1);
    chk("done", 1'h1, core_cyc_done);
  endtask : wait_done
  task automatic start(input sgs_pkg::sgs_kind_t k, input logic wr, input logic [1:0] lb);
    core_cyc_kind = k;
    core_cyc_write = wr;
    core_cyc_last_beat = lb;
    core_cyc_req = 1'h1;
    cyc(1);
    core_cyc_req = 1'h0;
    chk("busy", 1'h1, core_cyc_busy);
  endtask : start
  task automatic t_kinds();
    sgs_pkg::sgs_kind_t ks[6] = '{sgs_pkg::SGS_KIND_MEM, sgs_pkg::SGS_KIND_MEM, sgs_pkg::SGS_KIND_CODE,
                                  sgs_pkg::SGS_KIND_IO, sgs_pkg::SGS_KIND_IO, sgs_pkg::SGS_KIND_INTA};
    logic ws[6] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
    for (int i = 0; i < 6; i++) begin
      wait_cyc = 2'(i);
      start(ks[i], ws[i], (i == 0) ? 2'h3 : 2'h0);
      wait_ads();
      chk("direction", ws[i], write_read);
      chk("drive", 1'h1, write_read_oe);
      chk("mem io", ks[i] inside {sgs_pkg::SGS_KIND_MEM, sgs_pkg::SGS_KIND_CODE}, mem_io);
      wait_done();
    end
  endtask : t_kinds
  task automatic t_na();
    wait_cyc = 2'h0;
    start(sgs_pkg::SGS_KIND_MEM, 1'h0, 2'h3);
    wait_ads();
    next_address_n = 1'h0;
    cyc(1);
    start(sgs_pkg::SGS_KIND_IO, 1'h1, 2'h0);
    next_address_n = 1'h1;
    wait_ads();
    chk("pipelined strobe", 1'h0, core_cyc_done);
    chk("pipelined dir", 1'h1, write_read);
    wait_done();
    cyc(1);
    wait_done();
  endtask : t_na
  task automatic t_backoff_n();
    wait_cyc = 2'h3;
    start(sgs_pkg::SGS_KIND_MEM, 1'h1, 2'h0);
    wait_ads();
    backoff_n = 1'h0;
    cyc(1);
    chk("float backoff", 1'h0, write_read_oe);
    backoff_n = 1'h1;
    wait_ads();
    chk("reissue dir", 1'h1, write_read);
    wait_done();
    wait_cyc = 2'h0;
  endtask : t_backoff_n
  task automatic t_hold();
    hold_request = 1'h1;
    for (int i = 0; i < 20 && hold_acknowledge !== 1'h1; i++) cyc(1);
    chk("hold ack", 1'h1, hold_acknowledge);
    chk("float hold", 1'h0, write_read_oe);
    hold_request = 1'h0;
    cyc(3);
    chk("hold ack off", 1'h0, hold_acknowledge);
  endtask : t_hold
  task automatic t_stop(input logic mask);
    write_buffer_mask = mask;
    write_buffer_empty_n = 1'h1;
    core_cyc_last_beat = 2'h0;
    stop_request_n = 1'h0;
    core_bus_pending = 1'h1;
    cyc(4);
    chk("run until boundary", 1'h1, core_clk_run);
    core_boundary = 1'h1;
    cyc(1);
    core_boundary = 1'h0;
    cyc(1);
    chk("core halted", 1'h0, core_clk_run);
    chk("flushing", 1'h1, core_flush);
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      chk("drain wait", 1'h1, address_strobe_n);
    end
    core_bus_pending = 1'h0;
    wait_ads();
    chk("spec wr", 1'h1, write_read);
    chk("spec cache", 1'h1, cache_ind);
    chk("spec mio", 1'h0, mem_io);
    chk("spec dc", 1'h0, data_code);
    cyc(6);
    chk("grant wait", mask, stop_grant_state);
    write_buffer_empty_n = 1'h0;
    cyc(3);
    chk("grant", 1'h1, stop_grant_state);
    bus_clock_stopped = 1'h1;
    cyc(2);
    chk("stop clock", 1'h1, stop_clock_state);
    stop_request_n = 1'h1;
    cyc(3);
    chk("held while stopped", 1'h0, core_clk_run);
    bus_clock_stopped = 1'h0;
    cyc(3);
    chk("resumed", 1'h1, core_clk_run);
  endtask : t_stop
  // hang guard, well above the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    cyc(3);
    srst = 1'h0;
    t_kinds();
    t_na();
    t_backoff_n();
    t_hold();
    t_stop(1'h1);
    t_stop(1'h0);
    end_sim();
  end
endmodule : tb
